// file: logic/sbst_tap.sv
// Boundary-scan test access port of a pipelined memory, sampled on the system clock
`timescale 1ns/1ps
`include "sbst_consts.svh"
// How it works
// - Instruction 3 bits, bypass 1, identification 32, boundary chain 71 bits.
// - Code 000 captures the pin ring, scans it, floats memory outputs.
// - Code 001 loads and scans the identification word; memory unaffected.
// - Code 010 captures the pin ring, scans it, floats memory outputs.
// - Code 100 captures the pin ring and scans it; memory unaffected.
// - Code 111 scans through the one-bit bypass; memory unaffected.
// - Identification bit 0 is always one.
// - Identification bits 11:1 hold a fixed vendor code.
// - Identification bits 31:29 hold a fixed revision.
// - Bits 28:24 depth, 23:18 type, 17:12 device, all fixed.
// - Mode select high for five test clock rises resets the port.
// - Power-up and port reset load the identification instruction.
// - Capture-instruction loads 01 into the low instruction bits.
// - Serial input taken on test clock rise, output changes on fall.
module sbst_tap
  import sbst_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   arst_n_i,
  input  wire logic                   tck_i,
  input  wire logic                   tms_i,
  input  wire logic                   tdi_i,
  input  wire logic [`SBST_BSR_W-1:0] pin_ring_i,
  output logic                        tdo_o,
  output logic                        tdo_oe_n_o,
  output logic                        mem_hiz_o,
  output logic [`SBST_IR_W-1:0]       instr_o
);
  logic [1:0] rst_sync_q;
  wire        rst_n = rst_sync_q[1];
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // Two-stage synchronisers; only the second stage is read
  logic [2:0] sy1_q;
  logic [2:0] sy2_q;
  logic       tck_d1_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sy1_q    <= 3'h0;
      sy2_q    <= 3'h0;
      tck_d1_q <= 1'b0;
    end else begin
      sy1_q    <= {tck_i, tms_i, tdi_i};
      sy2_q    <= sy1_q;
      tck_d1_q <= sy2_q[2];
    end
  end
  wire tck_s = sy2_q[2];
  wire tms_s = sy2_q[1];
  wire tdi_s = sy2_q[0];
  wire rise  = tck_s && !tck_d1_q;
  wire fall  = !tck_s && tck_d1_q;

  // The output bit is pushed a clock after the rise, once the state and LSB have moved
  logic rise_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) rise_q <= 1'b0;
    else rise_q <= rise;
  end

  // Pin ring comes from the memory clock side; a ring in motion may capture mixed bits
  logic [`SBST_BSR_W-1:0] ring1_q;
  logic [`SBST_BSR_W-1:0] ring2_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ring1_q <= '0;
      ring2_q <= '0;
    end else begin
      ring1_q <= pin_ring_i;
      ring2_q <= ring1_q;
    end
  end

  sbst_state_e st_q;
  sbst_state_e st_d;
  always_comb begin
    case (st_q)
      SBST_RESET:    st_d = tms_s ? SBST_RESET   : SBST_IDLE;
      SBST_IDLE:     st_d = tms_s ? SBST_SEL_DR  : SBST_IDLE;
      SBST_SEL_DR:   st_d = tms_s ? SBST_SEL_IR  : SBST_CAP_DR;
      SBST_CAP_DR:   st_d = tms_s ? SBST_EXIT1_DR : SBST_SHIFT_DR;
      SBST_SHIFT_DR: st_d = tms_s ? SBST_EXIT1_DR : SBST_SHIFT_DR;
      SBST_EXIT1_DR: st_d = tms_s ? SBST_UPD_DR  : SBST_PAUSE_DR;
      SBST_PAUSE_DR: st_d = tms_s ? SBST_EXIT2_DR : SBST_PAUSE_DR;
      SBST_EXIT2_DR: st_d = tms_s ? SBST_UPD_DR  : SBST_SHIFT_DR;
      SBST_UPD_DR:   st_d = tms_s ? SBST_SEL_DR  : SBST_IDLE;
      SBST_SEL_IR:   st_d = tms_s ? SBST_RESET   : SBST_CAP_IR;
      SBST_CAP_IR:   st_d = tms_s ? SBST_EXIT1_IR : SBST_SHIFT_IR;
      SBST_SHIFT_IR: st_d = tms_s ? SBST_EXIT1_IR : SBST_SHIFT_IR;
      SBST_EXIT1_IR: st_d = tms_s ? SBST_UPD_IR  : SBST_PAUSE_IR;
      SBST_PAUSE_IR: st_d = tms_s ? SBST_EXIT2_IR : SBST_PAUSE_IR;
      SBST_EXIT2_IR: st_d = tms_s ? SBST_UPD_IR  : SBST_SHIFT_IR;
      SBST_UPD_IR:   st_d = tms_s ? SBST_SEL_DR  : SBST_IDLE;
      default:       st_d = SBST_RESET;
    endcase
  end

  // Decode of the active instruction
  logic [`SBST_IR_W-1:0]  ir_q;
  logic [`SBST_IR_W-1:0]  ir_sh_q;
  logic                   byp_q;
  logic [`SBST_ID_W-1:0]  id_sh_q;
  logic [`SBST_BSR_W-1:0] bsr_q;
  wire sel_id   = (ir_q == `SBST_OP_IDCODE);
  wire sel_bsr  = (ir_q == `SBST_OP_EXTEST) || (ir_q == `SBST_OP_SAMPLEZ)
                  || (ir_q == `SBST_OP_SAMPLE);
  // Reserved codes fall through to bypass
  wire sel_byp  = !sel_id && !sel_bsr;
  wire hiz      = (ir_q == `SBST_OP_EXTEST) || (ir_q == `SBST_OP_SAMPLEZ);
  wire [`SBST_ID_W-1:0] id_word = {`SBST_ID_REV, `SBST_ID_DEPTH, `SBST_ID_TYPE,
                                   `SBST_ID_DEVICE, `SBST_ID_VENDOR,
                                   `SBST_ID_PRESENT};
  wire in_shift_dr = (st_q == SBST_SHIFT_DR);
  wire in_shift_ir = (st_q == SBST_SHIFT_IR);
  wire dr_bit   = sel_id ? id_sh_q[0] : (sel_bsr ? bsr_q[0] : byp_q);
  wire out_bit  = in_shift_ir ? ir_sh_q[0] : dr_bit;
  wire shifting = in_shift_ir || in_shift_dr;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= SBST_RESET;
      ir_q    <= `SBST_OP_IDCODE;
      ir_sh_q <= `SBST_IR_CAPTURE;
      byp_q   <= 1'b0;
      id_sh_q <= '0;
      bsr_q   <= '0;
    end else if (rise) begin
      st_q <= st_d;
      case (st_q)
        SBST_RESET:    ir_q    <= `SBST_OP_IDCODE;
        SBST_CAP_IR:   ir_sh_q <= `SBST_IR_CAPTURE;
        SBST_SHIFT_IR: ir_sh_q <= {tdi_s, ir_sh_q[`SBST_IR_W-1:1]};
        SBST_UPD_IR:   ir_q    <= ir_sh_q;
        SBST_CAP_DR: begin
          byp_q   <= 1'b0;
          if (sel_id) id_sh_q <= id_word;
          if (sel_bsr) bsr_q <= ring2_q;
        end
        SBST_SHIFT_DR: begin
          byp_q   <= tdi_s;
          id_sh_q <= {tdi_s, id_sh_q[`SBST_ID_W-1:1]};
          bsr_q   <= {tdi_s, bsr_q[`SBST_BSR_W-1:1]};
        end
        default: ;
      endcase
    end
  end

  // Each output bit enters the buffer just after the rise and leaves at the next fall
  logic buf_in_rdy;
  logic buf_vld;
  logic buf_data;
  logic buf_oe;
  sbst_out_buf u_buf (
    .clk_i       (ref_clk_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (rise_q),
    .in_ready_o  (buf_in_rdy),
    .in_data_i   (out_bit),
    .in_oe_i     (shifting),
    .out_valid_o (buf_vld),
    .out_ready_i (fall),
    .out_data_o  (buf_data),
    .out_oe_o    (buf_oe)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tdo_o      <= 1'b0;
      tdo_oe_n_o <= 1'b1;
      mem_hiz_o  <= 1'b0;
      instr_o    <= `SBST_OP_IDCODE;
    end else begin
      if (fall && buf_vld) begin
        tdo_o      <= buf_data;
        tdo_oe_n_o <= !buf_oe;
      end
      mem_hiz_o <= hiz;
      instr_o   <= ir_q;
    end
  end

  // Five edges of mode select high reach reset from any state
  logic [2:0] tms_hi_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) tms_hi_q <= 3'h0;
    else if (rise) tms_hi_q <= !tms_s ? 3'h0 : (tms_hi_q == 3'h5 ? tms_hi_q : tms_hi_q + 3'h1);
  end

  tms_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    tms_hi_q == 3'h5 |-> st_q == SBST_RESET) else $error("five mode-high edges missed reset");
  reset_ir_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    rise && st_q == SBST_RESET |=> ir_q == 3'h1) else $error("reset did not load id instr");
  cap_ir_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    rise && st_q == SBST_CAP_IR |=> ir_sh_q[1:0] == 2'h1) else $error("capture pattern wrong");
  id_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    rise && st_q == SBST_CAP_DR && ir_q == 3'h1 |=> id_sh_q[0] == 1'b1 && id_sh_q[11:1] == 11'h2aa)
    else $error("id word wrong");
  id_fields_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    id_word[31:12] == 20'hb556a) else $error("id fields wrong");
  bsr_cap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    rise && st_q == SBST_CAP_DR && ir_q inside {3'h0, 3'h2, 3'h4} |=> bsr_q == $past(ring2_q))
    else $error("ring not captured");
  hiz_out_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ##1 mem_hiz_o == ($past(ir_q) == 3'h0 || $past(ir_q) == 3'h2)) else $error("high-z wrong");
  rsvd_hiz_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    ir_q inside {3'h3, 3'h5, 3'h6} |=> !mem_hiz_o) else $error("reserved code floated memory");
  byp_shift_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    rise && st_q == SBST_SHIFT_DR |=> byp_q == $past(tdi_s)) else $error("bypass shift wrong");
  tdo_fall_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n)
    $changed(tdo_o) |-> $past(fall)) else $error("serial out changed off fall");
  cv_ir_load_c: cover property (@(posedge ref_clk_i) rise && st_q == SBST_UPD_IR);
  cv_id_shift_c: cover property (@(posedge ref_clk_i) in_shift_dr && sel_id && rise);
  cv_bsr_shift_c: cover property (@(posedge ref_clk_i) in_shift_dr && sel_bsr && rise);
  cv_reserved_c: cover property (@(posedge ref_clk_i) sel_byp && ir_q != 3'h7);
endmodule : sbst_tap

// file: logic/sbst_consts.svh
// Constants of the memory boundary-scan test port
`ifndef SBST_CONSTS_SVH
`define SBST_CONSTS_SVH
`define SBST_IR_W        3
`define SBST_ID_W        32
`define SBST_BSR_W       71
`define SBST_IR_CAPTURE  3'h1
`define SBST_OP_EXTEST   3'h0
`define SBST_OP_IDCODE   3'h1
`define SBST_OP_SAMPLEZ  3'h2
`define SBST_OP_SAMPLE   3'h4
`define SBST_OP_BYPASS   3'h7
// Identification fields below are arbitrary values of our own
`define SBST_ID_PRESENT  1'h1
`define SBST_ID_VENDOR   11'h2aa
`define SBST_ID_REV      3'h5
`define SBST_ID_DEPTH    5'h15
`define SBST_ID_TYPE     6'h15
`define SBST_ID_DEVICE   6'h2a
`define SBST_RST_EDGES   5
`define SBST_BUF_DEPTH   2
`endif

// file: logic/sbst_pkg.sv
// Types of the memory boundary-scan test port
package sbst_pkg;
  typedef enum logic [3:0] {
    SBST_RESET, SBST_IDLE, SBST_SEL_DR, SBST_CAP_DR, SBST_SHIFT_DR, SBST_EXIT1_DR,
    SBST_PAUSE_DR, SBST_EXIT2_DR, SBST_UPD_DR, SBST_SEL_IR, SBST_CAP_IR, SBST_SHIFT_IR,
    SBST_EXIT1_IR, SBST_PAUSE_IR, SBST_EXIT2_IR, SBST_UPD_IR
  } sbst_state_e;
endpackage : sbst_pkg

// file: logic/sbst_out_buf.sv
// Two-entry valid/ready buffer carrying serial output bits
`timescale 1ns/1ps
`include "sbst_consts.svh"
module sbst_out_buf (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic in_valid_i,
  output logic      in_ready_o,
  input  wire logic in_data_i,
  input  wire logic in_oe_i,
  output logic      out_valid_o,
  input  wire logic out_ready_i,
  output logic      out_data_o,
  output logic      out_oe_o
);
  logic [1:0] mem_q [`SBST_BUF_DEPTH];
  logic       wr_q;
  logic       rd_q;
  logic [1:0] cnt_q;
  wire        push = in_valid_i && in_ready_o;
  wire        pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rd_q][0];
  assign out_oe_o    = mem_q[rd_q][1];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= 2'h0;
      mem_q[1] <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wr_q] <= {in_oe_i, in_data_i};
        wr_q        <= ~wr_q;
      end
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : sbst_out_buf

// file: dv/sbst_jtag_ctrl.sv
// Board test controller model driving the serial test pins of the memory
`timescale 1ns/1ps
module sbst_jtag_ctrl (
  input  wire logic ref_clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_n_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  // Test clock stands low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One test clock of 160 ns; tdo is taken late in the low phase, well after the fall
  task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
    tms_o = tms;
    tdi_o = tdi;
    repeat (8) @(negedge ref_clk_i);
    tdo   = tdo_i;
    oe_n  = tdo_oe_n_i;
    tck_o = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    tck_o = 1'b0;
  endtask : step

  task automatic tap_reset();
    logic d;
    logic o;
    repeat (5) step(1'b1, 1'b0, d, o);
    step(1'b0, 1'b0, d, o);
  endtask : tap_reset

  // From Idle: scan n bits LSB first through the instruction or data path, back to Idle
  task automatic scan(input logic ir, input logic [70:0] din, input int n,
                      output logic [70:0] dout, output logic oe_ok);
    logic d;
    logic o;
    oe_ok = 1'b1;
    dout  = '0;
    step(1'b1, 1'b0, d, o);
    if (ir) begin
      step(1'b1, 1'b0, d, o);
    end
    step(1'b0, 1'b0, d, o);
    step(1'b0, 1'b0, d, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d, o);
      dout[i] = d;
      if (o !== 1'b0) begin
        oe_ok = 1'b0;
      end
    end
    step(1'b1, 1'b0, d, o);
    step(1'b0, 1'b0, d, o);
  endtask : scan
endmodule : sbst_jtag_ctrl

// file: dv/sbst_tap_tb_top.sv
// Self-checking bench of the memory boundary-scan test port
`timescale 1ns/1ps
`include "sbst_consts.svh"
module sbst_tap_tb_top
  import sbst_pkg::*;
;
  localparam logic [31:0] ID_WORD = {`SBST_ID_REV, `SBST_ID_DEPTH, `SBST_ID_TYPE,
                                     `SBST_ID_DEVICE, `SBST_ID_VENDOR, `SBST_ID_PRESENT};
  logic                   ref_clk_i;
  logic                   arst_n_i;
  logic                   tck;
  logic                   tms;
  logic                   tdi;
  logic                   tdo_o;
  logic                   tdo_oe_n_o;
  logic                   mem_hiz_o;
  logic [`SBST_BSR_W-1:0] pin_ring;
  logic [`SBST_IR_W-1:0]  instr_o;
  logic [70:0]            din;
  logic [70:0]            dout;
  logic                   oe_ok;
  int                     fails;
  int                     check_count;
  int                     seed;

  sbst_tap u_sbst_tap (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .pin_ring_i(pin_ring), .tdo_o(tdo_o), .tdo_oe_n_o(tdo_oe_n_o),
    .mem_hiz_o(mem_hiz_o), .instr_o(instr_o));
  sbst_jtag_ctrl u_sbst_jtag_ctrl (.ref_clk_i(ref_clk_i), .tdo_i(tdo_o),
    .tdo_oe_n_i(tdo_oe_n_o), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic results();
    if ((fails == 0) && (check_count > 0)) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [70:0] got, input logic [70:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Captured word in the low bits, then the bits fed in behind it
  function automatic logic [70:0] exp_dr(input logic [2:0] code, input logic [70:0] d,
                                         input logic [70:0] ring);
    logic [141:0] t;
    int           len;
    logic [70:0]  cap;
    len = 1;
    cap = '0;
    if (code == `SBST_OP_IDCODE) begin
      len = 32;
      cap = 71'(ID_WORD);
    end else if (code inside {`SBST_OP_EXTEST, `SBST_OP_SAMPLEZ, `SBST_OP_SAMPLE}) begin
      len = 71;
      cap = ring;
    end
    t = {d, 71'h0} >> (71 - len);
    return t[70:0] | cap;
  endfunction : exp_dr

  // Reserved codes are sent to see that they fall back to bypass and leave the memory unaffected
  task automatic load(input logic [2:0] code);
    logic [70:0] cap;
    logic        ok;
    u_sbst_jtag_ctrl.scan(1'b1, 71'(code), 3, cap, ok);
    chk(cap & 71'h3, 71'h1);
    chk(71'(ok), 71'h1);
    chk(71'(instr_o), 71'(code));
    chk(71'(mem_hiz_o), 71'((code == 3'h0) || (code == 3'h2)));
  endtask : load

  initial begin
    repeat (100000) @(posedge ref_clk_i);
    fails++;
    results();
  end

  initial begin
    seed        = 57779;
    fails       = 0;
    check_count = 0;
    arst_n_i    = 1'b0;
    pin_ring    = '0;
    repeat (4) @(negedge ref_clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk(71'(instr_o), 71'(`SBST_OP_IDCODE));
    chk(71'(mem_hiz_o), 71'h0);
    chk(71'(tdo_oe_n_o), 71'h1);
    u_sbst_jtag_ctrl.tap_reset();
    for (int c = 0; c < 8; c++) begin
      load(3'(c));
      pin_ring = 71'({$random(seed), $random(seed), $random(seed)});
      din      = 71'({$random(seed), $random(seed), $random(seed)});
      u_sbst_jtag_ctrl.scan(1'b0, din, 71, dout, oe_ok);
      chk(dout, exp_dr(3'(c), din, pin_ring));
      chk(71'(oe_ok), 71'h1);
      chk(71'(tdo_oe_n_o), 71'h1);
    end
    // Reset in mid-run with the memory floated must bring back the id instruction
    load(`SBST_OP_SAMPLEZ);
    arst_n_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    chk(71'(instr_o), 71'(`SBST_OP_IDCODE));
    chk(71'(mem_hiz_o), 71'h0);
    arst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    u_sbst_jtag_ctrl.tap_reset();
    load(`SBST_OP_SAMPLEZ);
    u_sbst_jtag_ctrl.tap_reset();
    chk(71'(instr_o), 71'(`SBST_OP_IDCODE));
    chk(71'(mem_hiz_o), 71'h0);
    results();
  end
endmodule : sbst_tap_tb_top
